// File: design/uart_consts.svh
`ifndef UART_CONSTS_SVH
`define UART_CONSTS_SVH
`define ADDR_TX_CTRL 8'hd5
`define ADDR_RX_CTRL 8'hd6
`define ADDR_RELOAD 8'hd7
`define ADDR_TX_DATA 8'hd8
`define ADDR_RX_DATA 8'hd9
`define ADDR_IRQ_CTRL 8'hda
`define BIT_EN 7
`define BIT_PEN 6
`define BIT_PS 5
`define BIT_PC 4
`define BIT_FE 3
`define BIT_BRK 4
`define BIT_RXBZ 3
`define BIT_TXBZ 2
`define BIT_RXIE 3
`define BIT_TXIE 2
`define BIT_RXF 1
`define BIT_TXF 0
`define RELOAD_TOP 9'h100
`define DATA_BITS 4'h8
`define BREAK_BITS 5'h19
`define VEC_RX 16'h0013
`define VEC_TX 16'h0014
`endif

// File: design/uart_pkg.sv
`default_nettype none
package uart_pkg;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_PAR = 5'h08,
    TX_STOP = 5'h10
  } tx_state_e;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PAR = 5'h08,
    RX_STOP = 5'h10
  } rx_state_e;
endpackage
`default_nettype wire

// File: design/uart_transceiver_with_break.sv
// Implementation choice: strobed register access.
`include "uart_consts.svh"
`default_nettype none
module uart_transceiver_with_break (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic serial_in_pin_i,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_n_o,
  output logic rx_pin_uart_o,
  output logic rx_irq_o,
  output logic tx_irq_o,
  output logic [15:0] irq_vector_o
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and their next values
  logic [7:0] rx_ctrl, next_rx_ctrl;
  logic [7:0] tx_ctrl, next_tx_ctrl;
  logic [7:0] reload, next_reload;
  logic [7:0] tx_data, next_tx_data;
  logic [7:0] rx_data, next_rx_data;
  logic [3:0] irq_ctrl, next_irq_ctrl;
  logic [7:0] next_rdata;
  logic next_rx_irq, next_tx_irq;
  logic [15:0] next_vector;
  logic tx_start_req, next_tx_start_req;
  logic tx_done_ev, rx_done_ev, rx_pe_ev, rx_fe_ev;
  logic [7:0] rx_shift_final;
  logic tx_busy, rx_busy;

  ////////////////////////////////////////////////////////////////////////
  // Baud tick: prescaler then reload divider, one tick per half bit
  logic [6:0] pre_cnt, next_pre_cnt;
  logic [7:0] div_cnt, next_div_cnt;
  logic half_tick, next_half_tick;
  logic [6:0] pre_max;

  // Prescale code n divides by 2^n; half-bit uses 256-reload ticks
  always_comb begin
    pre_max = 7'((8'h01 << rx_ctrl[2:0]) - 8'h01);
    next_pre_cnt = pre_cnt;
    next_div_cnt = div_cnt;
    next_half_tick = 1'b0;
    if (pre_cnt >= pre_max) begin
      next_pre_cnt = 7'h00;
      if (div_cnt == 8'hff) begin
        next_div_cnt = reload;
        next_half_tick = 1'b1;
      end else begin
        next_div_cnt = div_cnt + 8'h01;
      end
    end else begin
      next_pre_cnt = pre_cnt + 7'h01;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pre_cnt <= 7'h00;
      div_cnt <= 8'h00;
      half_tick <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      div_cnt <= next_div_cnt;
      half_tick <= next_half_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive pin synchroniser
  logic rx_meta, rx_sync, rx_prev;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_meta <= serial_in_pin_i;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter; break reuses the data slots with the line held low
  uart_pkg::tx_state_e tx_st, next_tx_st;
  logic [4:0] tx_bits, next_tx_bits;
  logic tx_half, next_tx_half;
  logic [7:0] tx_sh, next_tx_sh;
  logic tx_line, next_tx_line;
  logic tx_par, next_tx_par;
  logic tx_brk_mode, next_tx_brk_mode;
  logic tx_brk_clr;

  always_comb begin
    next_tx_st = tx_st;
    next_tx_bits = tx_bits;
    next_tx_half = tx_half;
    next_tx_sh = tx_sh;
    next_tx_line = tx_line;
    next_tx_par = tx_par;
    next_tx_brk_mode = tx_brk_mode;
    tx_done_ev = 1'b0;
    tx_brk_clr = 1'b0;
    case (tx_st)
      uart_pkg::TX_IDLE: begin
        next_tx_line = 1'b1;
        if (tx_ctrl[`BIT_EN] && half_tick) begin
          if (tx_ctrl[`BIT_BRK]) begin
            next_tx_brk_mode = 1'b1;
            next_tx_bits = `BREAK_BITS;
            next_tx_line = 1'b0;
            next_tx_half = 1'b0;
            next_tx_st = uart_pkg::TX_DATA;
          end else if (tx_start_req) begin
            next_tx_brk_mode = 1'b0;
            next_tx_sh = tx_data;
            next_tx_par = tx_ctrl[`BIT_PS];
            next_tx_line = 1'b0;
            next_tx_half = 1'b0;
            next_tx_st = uart_pkg::TX_START;
          end
        end
      end
      uart_pkg::TX_START: begin
        if (half_tick) begin
          next_tx_half = ~tx_half;
          if (tx_half) begin
            next_tx_bits = {1'b0, `DATA_BITS};
            next_tx_line = tx_sh[0];
            next_tx_st = uart_pkg::TX_DATA;
          end
        end
      end
      uart_pkg::TX_DATA: begin
        if (half_tick) begin
          next_tx_half = ~tx_half;
          if (tx_half) begin
            next_tx_bits = tx_bits - 5'h01;
            if (!tx_brk_mode) begin
              next_tx_par = tx_par ^ tx_sh[0];
              next_tx_sh = {1'b0, tx_sh[7:1]};
              next_tx_line = tx_sh[1];
            end
            if (tx_bits == 5'h01) begin
              if (tx_brk_mode) begin
                next_tx_line = 1'b1;
                next_tx_st = uart_pkg::TX_IDLE;
                tx_done_ev = 1'b1;
                tx_brk_clr = 1'b1;
              end else if (tx_ctrl[`BIT_PEN]) begin
                next_tx_line = tx_par ^ tx_sh[0];
                next_tx_st = uart_pkg::TX_PAR;
              end else begin
                next_tx_line = 1'b1;
                next_tx_st = uart_pkg::TX_STOP;
              end
            end
          end
        end
      end
      uart_pkg::TX_PAR: begin
        if (half_tick) begin
          next_tx_half = ~tx_half;
          if (tx_half) begin
            next_tx_line = 1'b1;
            next_tx_st = uart_pkg::TX_STOP;
          end
        end
      end
      uart_pkg::TX_STOP: begin
        if (half_tick) begin
          next_tx_half = ~tx_half;
          if (tx_half) begin
            next_tx_st = uart_pkg::TX_IDLE;
            tx_done_ev = 1'b1;
          end
        end
      end
      default: next_tx_st = uart_pkg::TX_IDLE;
    endcase
    if (!tx_ctrl[`BIT_EN]) begin
      next_tx_st = uart_pkg::TX_IDLE;
      next_tx_line = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_st <= uart_pkg::TX_IDLE;
      tx_bits <= 5'h00;
      tx_half <= 1'b0;
      tx_sh <= 8'h00;
      tx_line <= 1'b1;
      tx_par <= 1'b0;
      tx_brk_mode <= 1'b0;
    end else begin
      tx_st <= next_tx_st;
      tx_bits <= next_tx_bits;
      tx_half <= next_tx_half;
      tx_sh <= next_tx_sh;
      tx_line <= next_tx_line;
      tx_par <= next_tx_par;
      tx_brk_mode <= next_tx_brk_mode;
    end
  end

  assign tx_busy = (tx_st != uart_pkg::TX_IDLE) | tx_start_req;

  ////////////////////////////////////////////////////////////////////////
  // Receiver; the tick is free running, so phase is kept by a half count
  // aligned at the start edge (up to one tick, half a bit, of jitter)
  uart_pkg::rx_state_e rx_st, next_rx_st;
  logic [3:0] rx_bits, next_rx_bits;
  logic rx_half, next_rx_half;
  logic [7:0] rx_sh, next_rx_sh;
  logic rx_par, next_rx_par;
  logic rx_ferr, next_rx_ferr;

  always_comb begin
    next_rx_st = rx_st;
    next_rx_bits = rx_bits;
    next_rx_half = rx_half;
    next_rx_sh = rx_sh;
    next_rx_par = rx_par;
    next_rx_ferr = rx_ferr;
    rx_done_ev = 1'b0;
    rx_pe_ev = 1'b0;
    rx_fe_ev = 1'b0;
    rx_shift_final = rx_sh;
    case (rx_st)
      uart_pkg::RX_IDLE: begin
        if (rx_ctrl[`BIT_EN] && rx_prev && !rx_sync) begin
          next_rx_half = 1'b0;
          next_rx_ferr = 1'b0;
          next_rx_par = rx_ctrl[`BIT_PS];
          next_rx_st = uart_pkg::RX_START;
        end
      end
      uart_pkg::RX_START: begin
        if (half_tick) begin
          next_rx_half = ~rx_half;
          if (!rx_half) begin
            next_rx_ferr = rx_sync;
          end else begin
            next_rx_bits = `DATA_BITS;
            next_rx_st = uart_pkg::RX_DATA;
          end
        end
      end
      uart_pkg::RX_DATA: begin
        if (half_tick) begin
          next_rx_half = ~rx_half;
          if (!rx_half) begin
            next_rx_sh = {rx_sync, rx_sh[7:1]};
            next_rx_par = rx_par ^ rx_sync;
          end else begin
            next_rx_bits = rx_bits - 4'h1;
            if (rx_bits == 4'h1) begin
              next_rx_st = rx_ctrl[`BIT_PEN] ? uart_pkg::RX_PAR :
                           uart_pkg::RX_STOP;
            end
          end
        end
      end
      uart_pkg::RX_PAR: begin
        if (half_tick) begin
          next_rx_half = ~rx_half;
          if (!rx_half) begin
            next_rx_par = rx_par ^ rx_sync;
          end else begin
            next_rx_st = uart_pkg::RX_STOP;
          end
        end
      end
      uart_pkg::RX_STOP: begin
        if (half_tick && !rx_half) begin
          // Mid stop bit: a low stop covers bad stop and break alike
          rx_done_ev = 1'b1;
          rx_fe_ev = rx_ferr | ~rx_sync;
          rx_pe_ev = rx_ctrl[`BIT_PEN] & rx_par;
          next_rx_st = uart_pkg::RX_IDLE;
        end
      end
      default: next_rx_st = uart_pkg::RX_IDLE;
    endcase
    if (!rx_ctrl[`BIT_EN]) begin
      next_rx_st = uart_pkg::RX_IDLE;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rx_st <= uart_pkg::RX_IDLE;
      rx_bits <= 4'h0;
      rx_half <= 1'b0;
      rx_sh <= 8'h00;
      rx_par <= 1'b0;
      rx_ferr <= 1'b0;
    end else begin
      rx_st <= next_rx_st;
      rx_bits <= next_rx_bits;
      rx_half <= next_rx_half;
      rx_sh <= next_rx_sh;
      rx_par <= next_rx_par;
      rx_ferr <= next_rx_ferr;
    end
  end

  // A held-low break never re-arms: idle needs a high before a new edge
  assign rx_busy = (rx_st != uart_pkg::RX_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Register file; hardware set wins over software clear
  always_comb begin
    next_rx_ctrl = rx_ctrl;
    next_tx_ctrl = tx_ctrl;
    next_reload = reload;
    next_tx_data = tx_data;
    next_rx_data = rx_data;
    next_irq_ctrl = irq_ctrl;
    next_tx_start_req = tx_start_req;
    next_rdata = 8'h00;
    // Launch consumes the request first, so a write in that cycle queues
    if (tx_st == uart_pkg::TX_IDLE && next_tx_st == uart_pkg::TX_START) begin
      next_tx_start_req = 1'b0;
    end
    if (wr_i) begin
      case (addr_i)
        `ADDR_RX_CTRL: next_rx_ctrl = wdata_i;
        `ADDR_TX_CTRL: next_tx_ctrl = {wdata_i[7:4], 4'h0};
        `ADDR_RELOAD: next_reload = wdata_i;
        `ADDR_TX_DATA: begin
          next_tx_data = wdata_i;
          next_tx_start_req = tx_ctrl[`BIT_EN];
        end
        `ADDR_RX_DATA: next_rx_data = wdata_i;
        `ADDR_IRQ_CTRL: next_irq_ctrl = wdata_i[3:0];
        default: ;
      endcase
    end
    if (tx_brk_clr) begin
      next_tx_ctrl[`BIT_BRK] = 1'b0;
    end
    if (tx_done_ev) begin
      next_irq_ctrl[`BIT_TXF] = 1'b1;
    end
    if (rx_done_ev) begin
      next_rx_data = rx_shift_final;
      next_irq_ctrl[`BIT_RXF] = 1'b1;
      next_rx_ctrl[`BIT_PC] = rx_pe_ev;
      next_rx_ctrl[`BIT_FE] = rx_fe_ev;
    end
    if (rd_i) begin
      case (addr_i)
        `ADDR_RX_CTRL: next_rdata = rx_ctrl;
        `ADDR_TX_CTRL: next_rdata = {tx_ctrl[7:4], rx_busy, tx_busy, 2'b00};
        `ADDR_RELOAD: next_rdata = reload;
        `ADDR_TX_DATA: next_rdata = tx_data;
        `ADDR_RX_DATA: next_rdata = rx_data;
        `ADDR_IRQ_CTRL: next_rdata = {4'h0, irq_ctrl};
        default: next_rdata = 8'h00;
      endcase
    end
    next_rx_irq = irq_ctrl[`BIT_RXIE] & irq_ctrl[`BIT_RXF];
    next_tx_irq = irq_ctrl[`BIT_TXIE] & irq_ctrl[`BIT_TXF];
    next_vector = next_rx_irq ? `VEC_RX : (next_tx_irq ? `VEC_TX : 16'h0000);
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rx_ctrl <= 8'h00;
      tx_ctrl <= 8'h00;
      reload <= 8'h00;
      tx_data <= 8'h00;
      rx_data <= 8'h00;
      irq_ctrl <= 4'h0;
      tx_start_req <= 1'b0;
      rdata_o <= 8'h00;
      rx_irq_o <= 1'b0;
      tx_irq_o <= 1'b0;
      irq_vector_o <= 16'h0000;
      serial_out_pin_o <= 1'b1;
      serial_out_pin_oe_n_o <= 1'b1;
      rx_pin_uart_o <= 1'b0;
    end else begin
      rx_ctrl <= next_rx_ctrl;
      tx_ctrl <= next_tx_ctrl;
      reload <= next_reload;
      tx_data <= next_tx_data;
      rx_data <= next_rx_data;
      irq_ctrl <= next_irq_ctrl;
      tx_start_req <= next_tx_start_req;
      rdata_o <= next_rdata;
      rx_irq_o <= next_rx_irq;
      tx_irq_o <= next_tx_irq;
      irq_vector_o <= next_vector;
      serial_out_pin_o <= next_tx_line;
      serial_out_pin_oe_n_o <= ~next_tx_ctrl[`BIT_EN];
      rx_pin_uart_o <= next_rx_ctrl[`BIT_EN];
    end
  end

endmodule
`default_nettype wire

// File: tb/uart_checker_properties.sv
`default_nettype none
module uart_checker (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic serial_in_pin_i,
  input wire logic serial_out_pin_o,
  input wire logic serial_out_pin_oe_n_o,
  input wire logic rx_pin_uart_o,
  input wire logic rx_irq_o,
  input wire logic tx_irq_o,
  input wire logic [15:0] irq_vector_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ps;
  logic [7:0] reload;
  int bit_len;
  int low_run;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////
  // Baud settings snooped off the register port, so timing is exact
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ps <= 3'h0;
      reload <= 8'h00;
    end else begin
      if (wr_i && addr_i == 8'hd6) ps <= wdata_i[2:0];
      if (wr_i && addr_i == 8'hd7) reload <= wdata_i;
    end
  end
  assign bit_len = 2 * (1 << ps) * (256 - reload);
  // Length of the current low stretch while the pin is driven
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || serial_out_pin_oe_n_o || serial_out_pin_o) low_run <= 0;
    else low_run <= low_run + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  chk_reset_quiet: assert property (disable iff (1'b0)
    rst_i |=> serial_out_pin_o && serial_out_pin_oe_n_o && !rx_pin_uart_o
      && !rx_irq_o && !tx_irq_o)
    else $error("outputs not quiet after reset");
  chk_idle_high: assert property (
    $fell(serial_out_pin_oe_n_o) |-> serial_out_pin_o)
    else $error("transmit pin not high when taken over");
  chk_tx_pin_owner: assert property (
    wr_i && addr_i == 8'hd5 |-> ##2
      serial_out_pin_oe_n_o == !$past(wdata_i[7], 2))
    else $error("transmit pin ownership wrong");
  chk_rx_pin_owner: assert property (
    wr_i && addr_i == 8'hd6 |-> ##2 rx_pin_uart_o == $past(wdata_i[7], 2))
    else $error("receive pin ownership wrong");
  chk_bit_timing: assert property (
    $rose(serial_out_pin_o) && !serial_out_pin_oe_n_o
      |-> low_run % bit_len == 0)
    else $error("low stretch not whole bit periods");
  chk_break_bound: assert property (
    low_run <= 25 * bit_len)
    else $error("transmit pin low too long");
  chk_vec_rx: assert property (
    rx_irq_o && $past(rx_irq_o) |-> irq_vector_o == 16'h0013)
    else $error("receive vector wrong");
  chk_vec_tx: assert property (
    tx_irq_o && $past(tx_irq_o) && !rx_irq_o && !$past(rx_irq_o)
      |-> irq_vector_o == 16'h0014)
    else $error("transmit vector wrong");
  chk_mask_clears: assert property (
    wr_i && addr_i == 8'hda && !wdata_i[3] && !wdata_i[2]
      |-> ##2 !rx_irq_o && !tx_irq_o)
    else $error("masked request still raised");
  chk_done_line_high: assert property (
    $rose(tx_irq_o) |-> serial_out_pin_o)
    else $error("transmit done while line low");
  cov_tx_done: cover property ($rose(tx_irq_o));
  cov_rx_done: cover property ($rose(rx_irq_o));
  cov_break: cover property (low_run == 25 * bit_len);
endmodule
`default_nettype wire

// File: tb/remote_uart.sv
`default_nettype none
module remote_uart (
  input wire logic sys_clk_i,
  input wire logic line_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int bit_clks = 16;
  int frames = 0;
  logic [10:0] cap;
  logic prev = 1'b1;
  initial line_o = 1'b1; // Remote holds the line high
  ////////////////////////////////////////////////////////////////////////
  // One frame; a low stop level lets a scenario spoil the framing
  task automatic send(input logic [7:0] d, input logic pen,
                      input logic pbit, input logic stop);
    logic [10:0] f;
    int n;
    f = {stop, pbit, d, 1'b0};
    n = pen ? 11 : 10;
    if (!pen) f[9] = stop;
    for (int i = 0; i < n; i++) begin
      line_o <= f[i];
      repeat (bit_clks) @(posedge sys_clk_i);
    end
    line_o <= 1'b1;
  endtask
  // Break of 88 us at 100 MHz, the shortest a bus reset may be
  task automatic brk();
    line_o <= 1'b0;
    repeat (8800) @(posedge sys_clk_i);
    line_o <= 1'b1;
  endtask
  // Mid-bit sampler of the device's pin: start, data, two more bits
  always @(posedge sys_clk_i) begin
    if (prev && !line_i) begin
      repeat (bit_clks / 2) @(posedge sys_clk_i);
      for (int i = 0; i < 11; i++) begin
        cap[i] = line_i;
        if (i < 10) repeat (bit_clks) @(posedge sys_clk_i);
      end
      frames++;
    end
    prev = line_i;
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst, wr_en, rd_en, rx_line, tx_out, oe_n, rx_own;
  logic rx_irq, tx_irq, tx_line;
  logic [7:0] addr, wdata, rdata;
  logic [15:0] vec;
  int num_errors = 0;
  int comparisons = 0;
  int lows = 0;
  uart_transceiver_with_break uart_transceiver_with_break_i (
    .sys_clk_i(sys_clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_en), .rd_i(rd_en), .rdata_o(rdata),
    .serial_in_pin_i(rx_line), .serial_out_pin_o(tx_out),
    .serial_out_pin_oe_n_o(oe_n), .rx_pin_uart_o(rx_own),
    .rx_irq_o(rx_irq), .tx_irq_o(tx_irq), .irq_vector_o(vec));
  remote_uart remote_uart_i (
    .sys_clk_i(sys_clk), .line_i(tx_line), .line_o(rx_line));
  // A released pin is pulled up, so the far side then reads high
  assign tx_line = oe_n ? 1'b1 : tx_out;
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk; // No noise filter here
  end
  // Low time on the transmit pin measures the bit period
  always @(posedge sys_clk) if (tx_line === 1'b0) lows++;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string w, input logic [15:0] s,
                       input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bus cycles: a spare edge after each keeps strobes single-driven
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    logic [7:0] d;
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    // Data stand for this one cycle; take them at its closing edge
    @(posedge sys_clk);
    d = rdata;
    check($sformatf("reg %h", a), {8'h00, d & m}, {8'h00, e});
  endtask
  task automatic wait_irq(input logic rx);
    int n;
    n = 0;
    while ((rx ? rx_irq : tx_irq) !== 1'b1) begin
      @(posedge sys_clk);
      n++;
      if (n > 20000) begin
        num_errors++;
        final_report();
      end
    end
  endtask
  task automatic tx_frame(input logic [7:0] ctl, input logic [7:0] d,
                          input logic [10:0] x, input int nlow);
    int b;
    b = remote_uart_i.bit_clks;
    wr(8'hd5, ctl);
    lows = 0;
    wr(8'hd8, d);
    rc(8'hd5, 8'h04, 8'h04);
    check("oe_n", {15'h0, oe_n}, 16'h0000);
    wait_irq(1'b0);
    rc(8'hda, 8'h01, 8'h01);
    check("vector", vec, 16'h0014);
    rc(8'hd5, 8'h04, 8'h00);
    repeat (2 * b) @(posedge sys_clk);
    check("frame", {5'h0, remote_uart_i.cap}, {5'h0, x});
    check("low time", 16'(lows), 16'(nlow * b));
    wr(8'hda, 8'h0c);
  endtask
  task automatic rx_frame(input logic [7:0] ctl, input logic p,
                          input logic s, input logic [7:0] fl);
    wr(8'hd6, ctl);
    fork
      remote_uart_i.send(8'h5a, ctl[6], p, s);
    join_none
    repeat (40) @(posedge sys_clk);
    rc(8'hd5, 8'h08, 8'h08);
    wait_irq(1'b1);
    check("rx own", {15'h0, rx_own}, 16'h0001);
    rc(8'hd9, 8'hff, 8'h5a);
    rc(8'hd6, 8'h18, fl);
    check("vector", vec, 16'h0013);
    wr(8'hda, 8'h0c);
    repeat (32) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic scen_regs();
    wr(8'hd4, 8'hff);
    for (int a = 8'hd4; a < 8'hdc; a++) rc(a[7:0], 8'hff, 8'h00);
  endtask
  task automatic scen_tx();
    wr(8'hd6, 8'h01);
    wr(8'hd7, 8'hfc);
    wr(8'hda, 8'h0c);
    rc(8'hd7, 8'hff, 8'hfc);
    rc(8'hd6, 8'h07, 8'h01);
    tx_frame(8'h80, 8'ha5, {2'b11, 8'ha5, 1'b0}, 5);
    for (int o = 0; o < 2; o++)
      tx_frame(8'hc0 | 8'(o << 5), 8'h07, {1'b1, 1'(o ^ 1), 8'h07, 1'b0},
               6 + o);
  endtask
  task automatic scen_baud();
    for (int c = 0; c < 8; c++) begin
      wr(8'hd6, 8'(c));
      wr(8'hd7, 8'hfe); // Never the forbidden top value
      remote_uart_i.bit_clks = 4 << c;
      tx_frame(8'h80, 8'h3c, {2'b11, 8'h3c, 1'b0}, 5);
    end
    wr(8'hd6, 8'h01);
    wr(8'hd7, 8'hfc);
    remote_uart_i.bit_clks = 16;
  endtask
  task automatic scen_rx();
    rx_frame(8'h81, 1'b0, 1'b1, 8'h00);
    rx_frame(8'hc1, 1'b0, 1'b1, 8'h00);
    rx_frame(8'he1, 1'b1, 1'b1, 8'h00);
    rx_frame(8'he1, 1'b0, 1'b1, 8'h10);
    rx_frame(8'h81, 1'b0, 1'b0, 8'h08);
  endtask
  task automatic scen_breaks();
    lows = 0;
    wr(8'hd5, 8'h90);
    wait_irq(1'b0);
    check("break", 16'(lows), 16'(25 * 16));
    rc(8'hd5, 8'h10, 8'h00);
    rc(8'hda, 8'h01, 8'h01);
    wr(8'hda, 8'h0c);
    wr(8'hd6, 8'h81);
    fork
      remote_uart_i.brk();
    join_none
    wait_irq(1'b1);
    rc(8'hd6, 8'h08, 8'h08);
    wr(8'hda, 8'h0c);
    repeat (9000) @(posedge sys_clk);
    check("rx idle", {15'h0, rx_irq}, 16'h0000);
    rx_frame(8'h81, 1'b0, 1'b1, 8'h00);
  endtask
  task automatic scen_off();
    int n;
    wr(8'hd5, 8'h00);
    wr(8'hd6, 8'h01);
    n = remote_uart_i.frames;
    wr(8'hd8, 8'h55);
    wr(8'hda, 8'h00);
    repeat (400) @(posedge sys_clk);
    check("oe_n", {15'h0, oe_n}, 16'h0001);
    check("rx own", {15'h0, rx_own}, 16'h0000);
    check("frames", 16'(remote_uart_i.frames - n), 16'h0000);
  endtask
  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    scen_regs();
    scen_tx();
    scen_baud();
    scen_rx();
    scen_breaks();
    scen_off();
    final_report();
  end
endmodule
bind uart_transceiver_with_break uart_checker uart_checker_i (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .serial_in_pin_i(serial_in_pin_i), .serial_out_pin_o(serial_out_pin_o),
  .serial_out_pin_oe_n_o(serial_out_pin_oe_n_o),
  .rx_pin_uart_o(rx_pin_uart_o), .rx_irq_o(rx_irq_o),
  .tx_irq_o(tx_irq_o), .irq_vector_o(irq_vector_o));
`default_nettype wire
